// ---- rtl/pcd_pkg.sv ----
// What this block does
// - change irq only while master enable set
// - flags still set with master enable clear
// - per-pin rising detector gated by enable
// - per-pin falling detector gated by enable
// - both enables set detect either edge
// - detected edge sets sticky pin flag
// - summary bit is or of all flags
// - writing zero clears a flag bit
// - edge during flag write wins over write
// - group a always, group b on large variant
// - each pin enabled independently
// - change event wakes from sleep when enabled
// - flags updated before wake is signalled
package pcd_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] PCD_ADDR_CTRL = 4'h0;
  localparam logic [3:0] PCD_ADDR_RISE_A = 4'h1;
  localparam logic [3:0] PCD_ADDR_FALL_A = 4'h2;
  localparam logic [3:0] PCD_ADDR_FLAG_A = 4'h3;
  localparam logic [3:0] PCD_ADDR_RISE_B = 4'h4;
  localparam logic [3:0] PCD_ADDR_FALL_B = 4'h5;
  localparam logic [3:0] PCD_ADDR_FLAG_B = 4'h6;
  localparam logic [3:0] PCD_ADDR_IRQ_STAT = 4'h7;
  localparam logic [3:0] PCD_ADDR_IRQ_MASK = 4'h8;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int PCD_PINS = 8;
  localparam int PCD_CTRL_EN_BIT = 0;
  localparam int PCD_CTRL_SUM_BIT = 1;
  localparam int PCD_STAT_A_BIT = 0;
  localparam int PCD_STAT_B_BIT = 1;
  localparam logic [7:0] PCD_RST_BYTE = 8'h00;
  localparam logic [1:0] PCD_RST_STAT = 2'h0;
endpackage

// ---- rtl/pcd_sync.sv ----
module pcd_sync
  import pcd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [PCD_PINS-1:0] pin_in,
  output logic [PCD_PINS-1:0] level_out,
  output logic [PCD_PINS-1:0] rise_out,
  output logic [PCD_PINS-1:0] fall_out
);
  // ****************************************
  // three stage capture
  // ****************************************
  logic [PCD_PINS-1:0] s1_q;
  logic [PCD_PINS-1:0] s2_q;
  logic [PCD_PINS-1:0] s3_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_q <= PCD_RST_BYTE;
      s2_q <= PCD_RST_BYTE;
      s3_q <= PCD_RST_BYTE;
      level_out <= PCD_RST_BYTE;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts only once the two later stages agree
      for (int i = 0; i < PCD_PINS; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_out[i] <= s3_q[i];
        end
      end
    end
  end
  // edge is current stable sample against the stored one
  assign rise_out = (s2_q & s3_q) & ~level_out;
  assign fall_out = ~(s2_q | s3_q) & level_out;
endmodule

// ---- rtl/pcd_port.sv ----
module pcd_port
  import pcd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [PCD_PINS-1:0] pin_in,
  input wire logic [PCD_PINS-1:0] rise_en_in,
  input wire logic [PCD_PINS-1:0] fall_en_in,
  input wire logic flag_wr_in,
  input wire logic [PCD_PINS-1:0] flag_wdata_in,
  output logic [PCD_PINS-1:0] flags_out,
  output logic event_out
);
  logic [PCD_PINS-1:0] rise;
  logic [PCD_PINS-1:0] fall;
  logic [PCD_PINS-1:0] hit;
  pcd_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(pin_in),
    .level_out(),
    .rise_out(rise),
    .fall_out(fall)
  );
  // ****************************************
  // edge qualification and flags
  // ****************************************
  assign hit = (rise & rise_en_in) | (fall & fall_en_in);
  assign event_out = |hit;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flags_out <= PCD_RST_BYTE;
    end else if (flag_wr_in) begin
      // a detected edge beats the written value
      flags_out <= (flags_out & flag_wdata_in) | hit;
    end else begin
      flags_out <= flags_out | hit;
    end
  end
endmodule

// ---- rtl/pcd_top.sv ----
module pcd_top
  import pcd_pkg::*;
#(
  parameter bit HAS_GROUP_B = 1'b1
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [PCD_PINS-1:0] pin_group_a_in,
  input wire logic [PCD_PINS-1:0] pin_group_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic sleep_in,
  output logic [7:0] rdata_out,
  output logic change_irq_out,
  output logic wake_out,
  output logic irq_out
);
  // ****************************************
  // registers
  // ****************************************
  logic change_irq_enable_q;
  logic [PCD_PINS-1:0] rise_a_q;
  logic [PCD_PINS-1:0] fall_a_q;
  logic [PCD_PINS-1:0] rise_b_q;
  logic [PCD_PINS-1:0] fall_b_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [PCD_PINS-1:0] port_a_change_flags;
  logic [PCD_PINS-1:0] port_b_change_flags;
  logic [PCD_PINS-1:0] rise_b_eff;
  logic [PCD_PINS-1:0] fall_b_eff;
  logic ev_a;
  logic ev_b;
  logic change_irq_summary;
  function automatic logic hit_addr(input logic [3:0] a);
    return wr_in && (addr_in == a);
  endfunction
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      change_irq_enable_q <= 1'b0;
      rise_a_q <= PCD_RST_BYTE;
      fall_a_q <= PCD_RST_BYTE;
      rise_b_q <= PCD_RST_BYTE;
      fall_b_q <= PCD_RST_BYTE;
      mask_q <= PCD_RST_STAT;
    end else begin
      if (hit_addr(PCD_ADDR_CTRL)) begin
        change_irq_enable_q <= wdata_in[PCD_CTRL_EN_BIT];
      end
      if (hit_addr(PCD_ADDR_RISE_A)) begin
        rise_a_q <= wdata_in;
      end
      if (hit_addr(PCD_ADDR_FALL_A)) begin
        fall_a_q <= wdata_in;
      end
      if (hit_addr(PCD_ADDR_RISE_B)) begin
        rise_b_q <= wdata_in;
      end
      if (hit_addr(PCD_ADDR_FALL_B)) begin
        fall_b_q <= wdata_in;
      end
      if (hit_addr(PCD_ADDR_IRQ_MASK)) begin
        mask_q <= wdata_in[1:0];
      end
    end
  end
  // small variant: group b detectors held off
  assign rise_b_eff = HAS_GROUP_B ? rise_b_q : PCD_RST_BYTE;
  assign fall_b_eff = HAS_GROUP_B ? fall_b_q : PCD_RST_BYTE;
  // ****************************************
  // pin groups
  // ****************************************
  pcd_port u_port_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(pin_group_a_in),
    .rise_en_in(rise_a_q),
    .fall_en_in(fall_a_q),
    .flag_wr_in(hit_addr(PCD_ADDR_FLAG_A)),
    .flag_wdata_in(wdata_in),
    .flags_out(port_a_change_flags),
    .event_out(ev_a)
  );
  pcd_port u_port_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(pin_group_b_in),
    .rise_en_in(rise_b_eff),
    .fall_en_in(fall_b_eff),
    .flag_wr_in(hit_addr(PCD_ADDR_FLAG_B)),
    .flag_wdata_in(wdata_in),
    .flags_out(port_b_change_flags),
    .event_out(ev_b)
  );
  // ****************************************
  // summary, request, wake
  // ****************************************
  assign change_irq_summary = |{port_a_change_flags, port_b_change_flags};
  assign change_irq_out = change_irq_summary & change_irq_enable_q;
  // wake follows the flags, so flags are already stored when it rises
  assign wake_out = sleep_in & change_irq_out;
  // software is expected to clear flags by masked and; the set wins anyway
  // ****************************************
  // sticky event status, write one to clear
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stat_q <= PCD_RST_STAT;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (hit_addr(PCD_ADDR_IRQ_STAT) && wdata_in[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      if (ev_a) begin
        stat_q[PCD_STAT_A_BIT] <= 1'b1;
      end
      if (ev_b) begin
        stat_q[PCD_STAT_B_BIT] <= 1'b1;
      end
    end
  end
  assign irq_out = |(stat_q & mask_q);
  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= PCD_RST_BYTE;
    end else if (rd_in) begin
      unique case (addr_in)
        PCD_ADDR_CTRL: rdata_out <= {6'h00, change_irq_summary, change_irq_enable_q};
        PCD_ADDR_RISE_A: rdata_out <= rise_a_q;
        PCD_ADDR_FALL_A: rdata_out <= fall_a_q;
        PCD_ADDR_FLAG_A: rdata_out <= port_a_change_flags;
        PCD_ADDR_RISE_B: rdata_out <= rise_b_eff;
        PCD_ADDR_FALL_B: rdata_out <= fall_b_eff;
        PCD_ADDR_FLAG_B: rdata_out <= port_b_change_flags;
        PCD_ADDR_IRQ_STAT: rdata_out <= {6'h00, stat_q};
        PCD_ADDR_IRQ_MASK: rdata_out <= {6'h00, mask_q};
        default: rdata_out <= PCD_RST_BYTE;
      endcase
    end
  end
endmodule

// ---- sim/pcd_properties.sv ----
module pcd_properties
  import pcd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [PCD_PINS-1:0] pin_group_a_in,
  input wire logic [PCD_PINS-1:0] pin_group_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic sleep_in,
  input wire logic [7:0] rdata_out,
  input wire logic change_irq_out,
  input wire logic wake_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ****
  // sequences
  // ****
  sequence ctrl_rd;
    rd_in && addr_in == PCD_ADDR_CTRL;
  endsequence
  // six quiet cycles cover the worst sync delay of four
  sequence quiet_bus;
    (!wr_in && $stable(pin_group_a_in) && $stable(pin_group_b_in)) [*6];
  endsequence
  // ****
  // checks
  // ****
  wake_follow_a: assert property (wake_out == (sleep_in && change_irq_out))
    else $error("wake level wrong");
  master_off_a: assert property
    (wr_in && addr_in == PCD_ADDR_CTRL && !wdata_in[PCD_CTRL_EN_BIT] |=> !change_irq_out)
    else $error("irq with master off");
  summary_read_a: assert property
    (ctrl_rd |=> (rdata_out[0] & rdata_out[1]) == $past(change_irq_out))
    else $error("summary read wrong");
  ctrl_upper_a: assert property (ctrl_rd |=> rdata_out[7:2] == 6'h00)
    else $error("ctrl upper bits set");
  unmapped_read_a: assert property
    (rd_in && addr_in > PCD_ADDR_IRQ_MASK |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  flag_sticky_a: assert property ($fell(change_irq_out) |-> $past(wr_in))
    else $error("flag fell alone");
  status_sticky_a: assert property ($fell(irq_out) |-> $past(wr_in))
    else $error("status fell alone");
  quiet_pins_a: assert property (quiet_bus |-> $stable(change_irq_out))
    else $error("irq moved on quiet pins");
endmodule

bind pcd_top pcd_properties i_pcd_properties (.*);

// ---- sim/pcd_pins_model.sv ----
module pcd_pins_model
  import pcd_pkg::*;
(
  input wire logic clk_in,
  output logic [PCD_PINS-1:0] pin_a_out,
  output logic [PCD_PINS-1:0] pin_b_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pin_a_out = 8'h00;
    pin_b_out = 8'h00;
  end
  // levels held six cycles: shorter pulses may slip past the sync
  task automatic drive(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_in);
    pin_a_out <= a;
    pin_b_out <= b;
    repeat (6) @(posedge clk_in);
    #1;
  endtask
endmodule

// ---- sim/pcd_top_test.sv ----
module pcd_top_test
  import pcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic sleep_in = 1'b0;
  wire logic [PCD_PINS-1:0] pin_group_a_in;
  wire logic [PCD_PINS-1:0] pin_group_b_in;
  logic [7:0] rdata_out;
  logic change_irq_out;
  logic wake_out;
  logic irq_out;
  int mismatches = 0;
  int n_compared = 0;
  pcd_top i_pcd_top (.*);
  pcd_pins_model i_pcd_pins_model (
    .clk_in(clk_in),
    .pin_a_out(pin_group_a_in),
    .pin_b_out(pin_group_b_in)
  );
  initial forever #5 clk_in = ~clk_in;
  // ****
  // tasks
  // ****
  task automatic tally_and_finish;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    cmp(rdata_out, exp);
  endtask
  // ****
  // tests
  // ****
  initial begin
    #50000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 10; i++) rd(4'(i), 8'h00);
    wr(PCD_ADDR_RISE_A, 8'h05);
    wr(PCD_ADDR_FALL_A, 8'h06);
    wr(PCD_ADDR_RISE_B, 8'h80);
    rd(PCD_ADDR_FALL_A, 8'h06);
    i_pcd_pins_model.drive(8'h07, 8'h00);
    rd(PCD_ADDR_FLAG_A, 8'h05);
    i_pcd_pins_model.drive(8'h00, 8'h00);
    rd(PCD_ADDR_FLAG_A, 8'h07);
    cmp(8'(change_irq_out), 8'h00);
    rd(PCD_ADDR_CTRL, 8'h02);
    wr(PCD_ADDR_CTRL, 8'h01);
    @(posedge clk_in);
    sleep_in <= 1'b1;
    #1;
    cmp({6'h00, wake_out, change_irq_out}, 8'h03);
    rd(PCD_ADDR_CTRL, 8'h03);
    wr(PCD_ADDR_FLAG_A, 8'hfe);
    rd(PCD_ADDR_FLAG_A, 8'h06);
    rd(PCD_ADDR_IRQ_STAT, 8'h01);
    cmp(8'(irq_out), 8'h00);
    wr(PCD_ADDR_IRQ_MASK, 8'h03);
    cmp(8'(irq_out), 8'h01);
    wr(PCD_ADDR_IRQ_STAT, 8'h01);
    cmp(8'(irq_out), 8'h00);
    i_pcd_pins_model.drive(8'h00, 8'h80);
    rd(PCD_ADDR_FLAG_B, 8'h80);
    cmp(8'(irq_out), 8'h01);
    rd(PCD_ADDR_IRQ_STAT, 8'h02);
    wr(PCD_ADDR_FLAG_A, 8'h00);
    wr(PCD_ADDR_FLAG_B, 8'h00);
    cmp({6'h00, wake_out, change_irq_out}, 8'h00);
    // the clearing write lands on the very edge that stores the rising pin
    fork
      i_pcd_pins_model.drive(8'h01, 8'h80);
      begin
        repeat (3) @(posedge clk_in);
        wr(PCD_ADDR_FLAG_A, 8'h00);
      end
    join
    rd(PCD_ADDR_FLAG_A, 8'h01);
    rd(PCD_ADDR_IRQ_STAT, 8'h03);
    // master off: flags stay, request and wake drop
    wr(PCD_ADDR_CTRL, 8'h00);
    cmp({6'h00, wake_out, change_irq_out}, 8'h00);
    rd(PCD_ADDR_CTRL, 8'h02);
    tally_and_finish;
  end
endmodule
